//--- aec_pkg.sv
package aec_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] AEC_OFF_CORR_STATUS = 12'h110;
    localparam logic [11:0] AEC_OFF_CORR_MASK = 12'h114;
    localparam logic [11:0] AEC_OFF_CTRL = 12'h118;
    localparam logic [11:0] AEC_OFF_HDR_WORD0 = 12'h11C;
    localparam logic [11:0] AEC_OFF_INT_STATUS = 12'h130;
    localparam logic [11:0] AEC_OFF_INT_MASK = 12'h134;
    localparam logic [11:0] AEC_OFF_MEM_CTRL = 12'h138;

    // ------------------------------------------------------------------
    // Correctable status and mask layout
    // ------------------------------------------------------------------
    localparam int AEC_BIT_RCV_ERR = 0;
    localparam int AEC_BIT_BAD_TLP = 6;
    localparam int AEC_BIT_BAD_DLLP = 7;
    localparam int AEC_BIT_REPLAY_ROLL = 8;
    localparam int AEC_BIT_REPLAY_TMO = 12;
    localparam int AEC_BIT_ADVISORY = 13;
    localparam int AEC_BIT_SINGLE_BIT = 31;
    localparam logic [31:0] AEC_CORR_VALID = 32'h800031C1;
    localparam logic [31:0] AEC_MASK_RESET = 32'h00002000;
    localparam logic [31:0] AEC_STATUS_RESET = 32'h00000000;

    // ------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------
    localparam int AEC_CTL_PTR_LSB = 0;
    localparam int AEC_CTL_PTR_W = 5;
    localparam int AEC_CTL_GEN_CAP = 5;
    localparam int AEC_CTL_GEN_EN = 6;
    localparam int AEC_CTL_CHK_CAP = 7;
    localparam int AEC_CTL_CHK_EN = 8;
    localparam logic AEC_GEN_CAP_RESET = 1'b1;
    localparam logic AEC_GEN_EN_RESET = 1'b0;
    localparam logic AEC_CHK_CAP_RESET = 1'b1;
    localparam logic AEC_CHK_EN_RESET = 1'b0;
    localparam logic [4:0] AEC_PTR_RESET = 5'h00;
    localparam logic [31:0] AEC_HDR_RESET = 32'h00000000;

    // ------------------------------------------------------------------
    // Interrupt and memory-error control layout
    // ------------------------------------------------------------------
    localparam int AEC_INT_CORR = 0;
    localparam int AEC_INT_UNCORR = 1;
    localparam int AEC_INT_W = 2;
    localparam logic [1:0] AEC_INT_RESET = 2'h0;
    localparam int AEC_MEM_REPORT_EN = 0;
    localparam int AEC_MEM_UNLOCK = 1;

endpackage

//--- aec_first_error_log.sv
`timescale 1ns/1ps
`default_nettype none
module aec_first_error_log
    import aec_pkg::*;
#(
    parameter int HDR_W = 32
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_event,
    input wire logic [4:0] i_bit,
    input wire logic [HDR_W-1:0] i_header,
    input wire logic [31:0] i_clear,
    output logic [4:0] o_ptr,
    output logic [HDR_W-1:0] o_header,
    output logic o_new
);

    // ------------------------------------------------------------------
    // Capture and freeze
    // ------------------------------------------------------------------
    logic logged_q;
    logic released;

    generate
        if (HDR_W != 32) begin : g_bad_width
            $error("aec_first_error_log supports only a 32-bit header word.");
        end
    endgenerate

    // The log reopens once software clears the status bit it points at.
    assign released = logged_q & i_clear[o_ptr];

    // A new error in the clearing cycle is kept, so nothing is lost.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            logged_q <= 1'b0;
            o_ptr <= AEC_PTR_RESET;
            o_header <= AEC_HDR_RESET;
            o_new <= 1'b0;
        end else begin
            o_new <= 1'b0;
            if (i_event && (!logged_q || released)) begin
                logged_q <= 1'b1;
                o_ptr <= i_bit;
                o_header <= i_header;
                o_new <= 1'b1;
            end else if (released) begin
                logged_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_first_capture: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (i_event && !logged_q) |=> (o_ptr == $past(i_bit)) && (o_header == $past(i_header))
            && o_new)
        else $error("First error was not captured.");

    chk_log_frozen: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (logged_q && !i_clear[o_ptr]) |=> $stable(o_ptr) && $stable(o_header) && !o_new)
        else $error("Logged first error changed while frozen.");

endmodule
`default_nettype wire

//--- aec_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Masked receiver, bad-packet and bad-link-packet events are not reported upward.
// - Masked replay rollover, replay timeout and advisory events are not reported upward.
// - Advisory mask resets to one; every other correctable mask bit resets to zero.
// - With memory reporting on, a masked single-bit error is recorded in status but not reported.
// - The single-bit mask never stops the matching status bit from recording.
// - With memory reporting off, the single-bit mask reads zero and ignores writes.
// - A five-bit read-only field holds the first reported uncorrectable error position.
// - Generation-capable bit resets to one and is writable only when unlocked.
// - Generation-enable bit turns on outgoing CRC generation; resets to zero.
// - Check-capable bit resets to one and is writable only when unlocked.
// - Check-enable bit turns on received CRC checking; resets to zero.
// - A read-only word holds the first header word of the first uncorrectable error.
// - Correctable status bits set on their event (the single-bit one only with memory reporting on) and clear by writing one.
module aec_top
    import aec_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [31:0] i_corr_event,
    input wire logic i_uncorr_event,
    input wire logic [4:0] i_uncorr_bit,
    input wire logic [31:0] i_uncorr_header,
    input wire logic [31:0] i_uncorr_clear,
    output logic o_corr_report,
    output logic o_crc_gen_enable,
    output logic o_crc_check_enable,
    output logic o_irq
);

    generate
        if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr
            $error("aec_top needs an address width from 9 to 32 bits.");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Avalon-MM slave handshake
    // ------------------------------------------------------------------
    logic wait_q;
    logic req;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [31:0] rdata_d;

    // Every access takes one wait cycle, so read data can come from a flop.
    assign req = (i_avs_read | i_avs_write) & wait_q;
    assign wr_en = i_avs_write & ~wait_q;
    assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    assign wdat = i_avs_writedata & wmask;

    // Waitrequest drops for exactly the cycle in which the access completes.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~req;
        end
    end

    assign o_avs_waitrequest = wait_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic hit_stat;
    logic hit_mask;
    logic hit_ctl;
    logic hit_hdr;
    logic hit_istat;
    logic hit_imask;
    logic hit_mem;

    // Matching the full byte address makes every other location unmapped.
    assign hit_stat = i_avs_address == ADDR_W'(AEC_OFF_CORR_STATUS);
    assign hit_mask = i_avs_address == ADDR_W'(AEC_OFF_CORR_MASK);
    assign hit_ctl = i_avs_address == ADDR_W'(AEC_OFF_CTRL);
    assign hit_hdr = i_avs_address == ADDR_W'(AEC_OFF_HDR_WORD0);
    assign hit_istat = i_avs_address == ADDR_W'(AEC_OFF_INT_STATUS);
    assign hit_imask = i_avs_address == ADDR_W'(AEC_OFF_INT_MASK);
    assign hit_mem = i_avs_address == ADDR_W'(AEC_OFF_MEM_CTRL);

    // ------------------------------------------------------------------
    // Memory-error control and write unlock
    // ------------------------------------------------------------------
    logic mem_en_q;
    logic unlock_q;

    // Both bits are plain read/write; unlock guards the capability bits.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mem_en_q <= 1'b0;
            unlock_q <= 1'b0;
        end else if (wr_en && hit_mem) begin
            if (wmask[AEC_MEM_REPORT_EN]) begin
                mem_en_q <= i_avs_writedata[AEC_MEM_REPORT_EN];
            end
            if (wmask[AEC_MEM_UNLOCK]) begin
                unlock_q <= i_avs_writedata[AEC_MEM_UNLOCK];
            end
        end
    end

    // ------------------------------------------------------------------
    // Correctable mask
    // ------------------------------------------------------------------
    logic [31:0] mask_q;
    logic [31:0] eff_mask;

    // Only documented mask bits are stored; the single-bit mask is held at
    // zero while memory reporting is off, which also makes it read zero.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mask_q <= AEC_MASK_RESET;
        end else begin
            if (wr_en && hit_mask) begin
                mask_q <= ((mask_q & ~wmask) | wdat) & AEC_CORR_VALID;
            end
            if (!mem_en_q) begin
                mask_q[AEC_BIT_SINGLE_BIT] <= 1'b0;
            end
        end
    end

    assign eff_mask = mask_q;

    // ------------------------------------------------------------------
    // Correctable status and upward reporting
    // ------------------------------------------------------------------
    logic [31:0] status_q;
    logic [31:0] corr_set;
    logic [31:0] corr_clr;
    logic [31:0] corr_unmasked;

    // Single-bit errors record only while memory reporting is enabled.
    assign corr_set = i_corr_event & AEC_CORR_VALID
                      & {mem_en_q, 31'h7FFFFFFF};
    assign corr_clr = (wr_en && hit_stat) ? wdat : 32'h00000000;
    assign corr_unmasked = corr_set & ~eff_mask;

    // One flop per documented bit; a set in the clearing cycle wins.
    generate
        for (genvar b = 0; b < 32; b++) begin : g_status
            if (AEC_CORR_VALID[b]) begin : g_flop
                always_ff @(posedge i_core_clk) begin
                    if (i_reset) begin
                        status_q[b] <= AEC_STATUS_RESET[b];
                    end else if (corr_set[b]) begin
                        status_q[b] <= 1'b1;
                    end else if (corr_clr[b] || (b == AEC_BIT_SINGLE_BIT && !mem_en_q)) begin
                        status_q[b] <= 1'b0;
                    end
                end
            end else begin : g_zero
                // Reserved positions get a constant flop too, so that every bit
                // of the status word has a procedural driver and none a continuous one.
                always_ff @(posedge i_core_clk) begin
                    status_q[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // A masked event still records status but sends nothing upward.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_corr_report <= 1'b0;
        end else begin
            o_corr_report <= |corr_unmasked;
        end
    end

    // ------------------------------------------------------------------
    // Control register and CRC enables
    // ------------------------------------------------------------------
    logic gen_cap_q;
    logic chk_cap_q;
    logic wr_ctl;

    assign wr_ctl = wr_en & hit_ctl;

    // The capability bits are locked unless software has unlocked writes.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            gen_cap_q <= AEC_GEN_CAP_RESET;
            chk_cap_q <= AEC_CHK_CAP_RESET;
        end else if (wr_ctl && unlock_q) begin
            if (wmask[AEC_CTL_GEN_CAP]) begin
                gen_cap_q <= i_avs_writedata[AEC_CTL_GEN_CAP];
            end
            if (wmask[AEC_CTL_CHK_CAP]) begin
                chk_cap_q <= i_avs_writedata[AEC_CTL_CHK_CAP];
            end
        end
    end

    // Enables drive the packet datapath directly from their storage flops.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_crc_gen_enable <= AEC_GEN_EN_RESET;
            o_crc_check_enable <= AEC_CHK_EN_RESET;
        end else if (wr_ctl) begin
            if (wmask[AEC_CTL_GEN_EN]) begin
                o_crc_gen_enable <= i_avs_writedata[AEC_CTL_GEN_EN];
            end
            if (wmask[AEC_CTL_CHK_EN]) begin
                o_crc_check_enable <= i_avs_writedata[AEC_CTL_CHK_EN];
            end
        end
    end

    // ------------------------------------------------------------------
    // First uncorrectable error log
    // ------------------------------------------------------------------
    logic [4:0] first_ptr;
    logic [31:0] first_hdr;
    logic first_new;

    aec_first_error_log #(
        .HDR_W(32)
    ) u_log (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_event(i_uncorr_event),
        .i_bit(i_uncorr_bit),
        .i_header(i_uncorr_header),
        .i_clear(i_uncorr_clear),
        .o_ptr(first_ptr),
        .o_header(first_hdr),
        .o_new(first_new)
    );

    // ------------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------------
    logic [AEC_INT_W-1:0] int_stat_q;
    logic [AEC_INT_W-1:0] int_mask_q;
    logic [AEC_INT_W-1:0] int_set;

    assign int_set = {first_new, o_corr_report};

    // Sticky bits, cleared by writing one; a new event beats the clear.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            int_stat_q <= AEC_INT_RESET;
        end else if (wr_en && hit_istat) begin
            int_stat_q <= (int_stat_q & ~wdat[AEC_INT_W-1:0]) | int_set;
        end else begin
            int_stat_q <= int_stat_q | int_set;
        end
    end

    // Plain read/write enables; a one lets the matching status bit raise the line.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            int_mask_q <= AEC_INT_RESET;
        end else if (wr_en && hit_imask) begin
            int_mask_q <= (int_mask_q & ~wmask[AEC_INT_W-1:0]) | wdat[AEC_INT_W-1:0];
        end
    end

    // Registered for a clean output; it trails the status by one cycle.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(int_stat_q & int_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unmapped addresses and reserved bits read as zero.
    always_comb begin
        rdata_d = 32'h00000000;
        case (1'b1)
            hit_stat: rdata_d = status_q;
            hit_mask: rdata_d = mask_q & AEC_CORR_VALID;
            hit_ctl: begin
                rdata_d[AEC_CTL_PTR_LSB +: AEC_CTL_PTR_W] = first_ptr;
                rdata_d[AEC_CTL_GEN_CAP] = gen_cap_q;
                rdata_d[AEC_CTL_GEN_EN] = o_crc_gen_enable;
                rdata_d[AEC_CTL_CHK_CAP] = chk_cap_q;
                rdata_d[AEC_CTL_CHK_EN] = o_crc_check_enable;
            end
            hit_hdr: rdata_d = first_hdr;
            hit_istat: rdata_d[AEC_INT_W-1:0] = int_stat_q;
            hit_imask: rdata_d[AEC_INT_W-1:0] = int_mask_q;
            hit_mem: begin
                rdata_d[AEC_MEM_REPORT_EN] = mem_en_q;
                rdata_d[AEC_MEM_UNLOCK] = unlock_q;
            end
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Captured as the read is taken, so it stands while waitrequest is low.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h00000000;
        end else if (req && i_avs_read) begin
            o_avs_readdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_masked_silent: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (corr_set != 32'h0 && corr_unmasked == 32'h0) |=> !o_corr_report)
        else $error("Masked correctable event was reported.");

    chk_unmasked_sent: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (corr_unmasked != 32'h0) |=> o_corr_report)
        else $error("Unmasked correctable event was not reported.");

    chk_mask_reset: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $past(i_reset) |-> (mask_q == AEC_MASK_RESET) && gen_cap_q && chk_cap_q
            && !o_crc_gen_enable && !o_crc_check_enable)
        else $error("Mask or control reset value wrong.");

    chk_sbe_recorded: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (i_corr_event[AEC_BIT_SINGLE_BIT] && mem_en_q) |=> status_q[AEC_BIT_SINGLE_BIT])
        else $error("Single-bit error not recorded in status.");

    chk_sbe_mask_off: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !mem_en_q |=> !mask_q[AEC_BIT_SINGLE_BIT])
        else $error("Single-bit mask set while memory reporting is off.");

    chk_cap_locked: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (wr_ctl && !unlock_q) |=> $stable(gen_cap_q) && $stable(chk_cap_q))
        else $error("Capability bit changed while locked.");

    chk_gen_follows: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (wr_ctl && wmask[AEC_CTL_GEN_EN])
            |=> o_crc_gen_enable == $past(i_avs_writedata[AEC_CTL_GEN_EN]))
        else $error("Generation enable did not follow the write.");

    chk_w1c_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (corr_clr[AEC_BIT_RCV_ERR] && !corr_set[AEC_BIT_RCV_ERR])
            |=> !status_q[AEC_BIT_RCV_ERR])
        else $error("Write-one-to-clear failed on receiver status.");

    chk_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (mask_q & ~AEC_CORR_VALID) == 32'h0 && (status_q & ~AEC_CORR_VALID) == 32'h0)
        else $error("Reserved bit became set.");

    chk_wait_once: assert property (@(posedge i_core_clk) disable iff (i_reset)
        req |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("Waitrequest did not drop for exactly one cycle.");

endmodule
`default_nettype wire

//--- aec_root_model.sv
`timescale 1ns/1ps
`default_nettype none
// Root complex stand-in: it only counts the correctable reports that reach it.
module aec_root_model (
    input wire logic i_core_clk,
    input wire logic i_report
);
    int reports = 0;
    // One pulse is one message; the tally is never cleared so the bench works on differences.
    always @(posedge i_core_clk) begin
        if (i_report === 1'b1) begin
            reports++;
        end
    end
endmodule
`default_nettype wire

//--- aec_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aec_top_tb;
    import aec_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] adr = '0;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic wreq;
    logic [31:0] cev = '0;
    logic uev = 1'b0;
    logic [4:0] ubit = '0;
    logic [31:0] uhdr = '0;
    logic [31:0] uclr = '0;
    logic rep, gen_en, chk_en, irq;
    int error_cnt = 0;
    int checked = 0;
    int n;
    int bits[6] = '{0, 6, 7, 8, 12, 13};

    aec_top i_dut (.i_core_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd_q),
        .i_avs_write(wr_q), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_corr_event(cev),
        .i_uncorr_event(uev), .i_uncorr_bit(ubit), .i_uncorr_header(uhdr),
        .i_uncorr_clear(uclr), .o_corr_report(rep), .o_crc_gen_enable(gen_en),
        .o_crc_check_enable(chk_en), .o_irq(irq));
    aec_root_model i_root (.i_core_clk(clk), .i_report(rep));

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The request is held until waitrequest is sampled low, then dropped for one idle cycle.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int k;
        k = 0;
        adr <= a;
        wr_q <= w;
        rd_q <= !w;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        q = rdat;
        if (k >= 50) chk("waitrequest", 32'(wreq), 32'h0);
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask

    // A one-cycle event burst, then time for the report to land at the root model.
    task automatic pulse(input logic [31:0] v);
        n = i_root.reports;
        cev <= v;
        @(posedge clk);
        cev <= '0;
        repeat (4) @(posedge clk);
    endtask

    task automatic ulog(input logic [4:0] b, input logic [31:0] h, input logic [31:0] c);
        uev <= 1'b1;
        ubit <= b;
        uhdr <= h;
        uclr <= c;
        @(posedge clk);
        uev <= 1'b0;
        uclr <= '0;
        repeat (3) @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang costs a mismatch and closes the run the ordinary way.
    initial begin
        #80000;
        error_cnt++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(AEC_OFF_CORR_MASK, 32'h00002000, "mask_reset");
        rd(AEC_OFF_CTRL, 32'h000000A0, "ctrl_reset");
        rd(AEC_OFF_HDR_WORD0, 32'h0, "hdr_reset");
        rd(12'h1F0, 32'h0, "unmapped");
        wr(AEC_OFF_CORR_MASK, 32'hFFFFFFFF);
        rd(AEC_OFF_CORR_MASK, 32'h000031C1, "mask_rsvd");
        wr(AEC_OFF_CTRL, 32'hFFFFFFFF);
        rd(AEC_OFF_CTRL, 32'h000001E0, "ctrl_rsvd");
        chk("gen_en", 32'(gen_en), 32'h1);
        chk("chk_en", 32'(chk_en), 32'h1);
        wr(AEC_OFF_CTRL, 32'h0);
        rd(AEC_OFF_CTRL, 32'h000000A0, "ctrl_locked");
        chk("gen_off", 32'({gen_en, chk_en}), 32'h0);
        wr(AEC_OFF_MEM_CTRL, 32'h2);
        wr(AEC_OFF_CTRL, 32'h0);
        rd(AEC_OFF_CTRL, 32'h0, "ctrl_unlocked");
        wr(AEC_OFF_CTRL, 32'hA0);
        wr(AEC_OFF_MEM_CTRL, 32'h0);
        $display("test registers done");
        // Each correctable source except single-bit: reported while open, silent but recorded while masked.
        foreach (bits[i]) begin
            wr(AEC_OFF_CORR_MASK, 32'h0);
            pulse(32'h1 << bits[i]);
            chk("report_open", 32'(i_root.reports - n), 32'h1);
            rd(AEC_OFF_CORR_STATUS, 32'h1 << bits[i], "status_set");
            wr(AEC_OFF_CORR_STATUS, 32'h1 << bits[i]);
            rd(AEC_OFF_CORR_STATUS, 32'h0, "status_w1c");
            wr(AEC_OFF_CORR_MASK, 32'h1 << bits[i]);
            pulse(32'h1 << bits[i]);
            chk("report_masked", 32'(i_root.reports - n), 32'h0);
            rd(AEC_OFF_CORR_STATUS, 32'h1 << bits[i], "status_masked");
            wr(AEC_OFF_CORR_STATUS, 32'hFFFFFFFF);
        end
        $display("test correctable done");
        wr(AEC_OFF_MEM_CTRL, 32'h1);
        wr(AEC_OFF_CORR_MASK, 32'h80000000);
        rd(AEC_OFF_CORR_MASK, 32'h80000000, "sbe_mask");
        pulse(32'h80000000);
        chk("sbe_masked", 32'(i_root.reports - n), 32'h0);
        rd(AEC_OFF_CORR_STATUS, 32'h80000000, "sbe_status");
        wr(AEC_OFF_CORR_STATUS, 32'h80000000);
        wr(AEC_OFF_CORR_MASK, 32'h0);
        pulse(32'h80000000);
        chk("sbe_open", 32'(i_root.reports - n), 32'h1);
        wr(AEC_OFF_CORR_STATUS, 32'h80000000);
        wr(AEC_OFF_MEM_CTRL, 32'h0);
        wr(AEC_OFF_CORR_MASK, 32'h80000000);
        rd(AEC_OFF_CORR_MASK, 32'h0, "sbe_off");
        $display("test single bit done");
        // First error is held; a clear of its bit in the same cycle as a new one reopens.
        ulog(5'd5, 32'h1234ABCD, 32'h0);
        rd(AEC_OFF_CTRL, 32'h000000A5, "ptr_first");
        rd(AEC_OFF_HDR_WORD0, 32'h1234ABCD, "hdr_first");
        ulog(5'd9, 32'h55AA0F0F, 32'h200);
        rd(AEC_OFF_CTRL, 32'h000000A5, "ptr_frozen");
        rd(AEC_OFF_HDR_WORD0, 32'h1234ABCD, "hdr_frozen");
        ulog(5'd9, 32'h55AA0F0F, 32'h20);
        rd(AEC_OFF_CTRL, 32'h000000A9, "ptr_reopen");
        rd(AEC_OFF_HDR_WORD0, 32'h55AA0F0F, "hdr_reopen");
        $display("test header log done");
        chk("irq_masked", 32'(irq), 32'h0);
        wr(AEC_OFF_INT_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq_on", 32'(irq), 32'h1);
        wr(AEC_OFF_INT_STATUS, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq_cleared", 32'(irq), 32'h0);
        $display("test interrupt done");
        end_of_test();
    end
endmodule
`default_nettype wire
